// ===== logic/acrc_core.sv
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acrc_params.svh"
// How it works
// - Complete flag sets when result registers load
// - Interrupt raised if enable high at completion
// - 10-bit high read blocks result overwrite
// - Blocked result dropped, flag not set for it
// - Single compare-false conversion stops when blocked
// - Otherwise blocked transfer restarts a conversion
// - Control-one write aborts, restarts unless all ones
// - Mode register writes abort running conversion
// - Stop without async clock aborts conversion
// - Aborts keep last good result
// - Reset aborts and clears result registers
// - Pin-control bit one disables port control
// - Third pin register maps channels 16-23
// - Second register bits 1,0 map channels 9,8
// - Channel field addresses 28, four built
// - Idle until started; async clock enabled then
// - Subsequent 10-bit conversion within 20 cycles
module acrc_core #(
  parameter int NUM_CH = 4
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter side
  input wire logic conv_tick,
  input wire logic [9:0] conv_data,
  input wire logic stop_mode,
  // Outputs
  output logic [4:0] conv_channel,
  output logic conv_active,
  output logic async_clk_enable,
  output logic [23:0] port_io_disable,
  output logic irq
);
  typedef struct packed {
    acrc_pkg::acrc_state_type st;
    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_addr;
    logic [7:0] sc1;
    logic [7:0] sc2;
    logic [7:0] cfg;
    logic [7:0] cvh;
    logic [7:0] cvl;
    logic [7:0] resh;
    logic [7:0] resl;
    logic [15:0] pc;
    logic [2:0] ist;
    logic [2:0] imsk;
    logic blocked;
    logic [7:0] cnt;
    logic [9:0] sample;
    logic [31:0] rdata;
  } acrc_regs_type;

  acrc_regs_type r_q;
  acrc_regs_type r_d;

  logic addr_ok;
  logic [31:0] rd_mux;
  logic mode10;
  logic cmp_true;
  logic [9:0] cmp_val;
  logic [7:0] conv_len;

  // Reads take one wait state so that hrdata can come straight from a flop
  assign hreadyout = !(r_q.ph_valid && !r_q.ph_write);
  assign hresp = 1'b0;
  assign hrdata = r_q.rdata;
  assign mode10 = r_q.cfg[`ACRC_CFG_MODE10];
  assign cmp_val = {r_q.cvh[1:0], r_q.cvl};
  assign conv_len = r_q.cfg[`ACRC_CFG_LSMP] ? `ACRC_CONV_CYC_LONG : `ACRC_CONV_CYC;
  assign cmp_true = r_q.sc2[`ACRC_SC2_CMPGT] ? (r_q.sample >= cmp_val) : (r_q.sample < cmp_val);
  assign conv_channel = r_q.sc1[4:0];
  assign conv_active = (r_q.st == acrc_pkg::ACRC_CONV);
  assign async_clk_enable = conv_active && r_q.cfg[`ACRC_CFG_ACLK];
  assign irq = |(r_q.ist & r_q.imsk);

  // Pin control: channels 8-15 from second register, 16-23 from third
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1)
    begin : g_pin
      if (gi < 8)
      begin : g_lo
        // Only the low NUM_CH inputs are built; no pin-control register
        assign port_io_disable[gi] = 1'b0;
      end
      else
      begin : g_hi
        assign port_io_disable[gi] = r_q.pc[gi-8];
      end
    end
  endgenerate

  // Read data mux
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (r_q.ph_addr)
      `ACRC_OFS_SC1: rd_mux[7:0] = r_q.sc1;
      `ACRC_OFS_SC2: rd_mux[7:0] = {conv_active, r_q.sc2[6:0]};
      `ACRC_OFS_RESH: rd_mux[7:0] = r_q.resh;
      `ACRC_OFS_RESL: rd_mux[7:0] = r_q.resl;
      `ACRC_OFS_CVH: rd_mux[7:0] = r_q.cvh;
      `ACRC_OFS_CVL: rd_mux[7:0] = r_q.cvl;
      `ACRC_OFS_CFG: rd_mux[7:0] = r_q.cfg;
      `ACRC_OFS_PC2: rd_mux[7:0] = r_q.pc[7:0];
      `ACRC_OFS_PC3: rd_mux[7:0] = r_q.pc[15:8];
      `ACRC_OFS_IST: rd_mux[2:0] = r_q.ist;
      `ACRC_OFS_IMSK: rd_mux[2:0] = r_q.imsk;
      `ACRC_OFS_CTRL: rd_mux[0] = r_q.blocked;
      default: addr_ok = 1'b0;
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    logic wr;
    logic rd;
    logic abort;
    logic start;
    logic [2:0] ev;
    logic xfer;
    wr = 1'b0;
    xfer = 1'b0;
    rd = 1'b0;
    abort = 1'b0;
    start = 1'b0;
    ev = 3'b000;
    r_d = r_q;
    // Address phase capture
    r_d.ph_valid = hsel && hready && htrans[1];
    r_d.ph_write = hwrite;
    r_d.ph_addr = haddr;
    wr = r_q.ph_valid && r_q.ph_write && addr_ok;
    rd = r_q.ph_valid && !r_q.ph_write && addr_ok;
    // Unmapped reads return zero
    if (rd)
    begin
      r_d.rdata = rd_mux;
    end
    else if (r_q.ph_valid)
    begin
      r_d.rdata = 32'h0000_0000;
    end
    // Read of the high byte in 10-bit mode locks the pair until low is read
    if (rd && mode10 && r_q.ph_addr == `ACRC_OFS_RESH)
    begin
      r_d.blocked = 1'b1;
    end
    if (rd && r_q.ph_addr == `ACRC_OFS_RESL)
    begin
      r_d.blocked = 1'b0;
    end
    // Register writes
    if (wr)
    begin
      unique case (r_q.ph_addr)
        `ACRC_OFS_SC1:
        begin
          r_d.sc1 = {1'b0, hwdata[6:5], hwdata[4:0]};
          abort = 1'b1;
          start = (hwdata[4:0] != `ACRC_CH_OFF);
        end
        `ACRC_OFS_SC2:
        begin
          r_d.sc2 = {1'b0, hwdata[6:0]};
          abort = 1'b1;
        end
        `ACRC_OFS_CFG:
        begin
          r_d.cfg = hwdata[7:0];
          abort = 1'b1;
        end
        `ACRC_OFS_CVH:
        begin
          r_d.cvh = hwdata[7:0];
          abort = 1'b1;
        end
        `ACRC_OFS_CVL:
        begin
          r_d.cvl = hwdata[7:0];
          abort = 1'b1;
        end
        `ACRC_OFS_PC2: r_d.pc[7:0] = hwdata[7:0];
        `ACRC_OFS_PC3: r_d.pc[15:8] = hwdata[7:0];
        `ACRC_OFS_IMSK: r_d.imsk = hwdata[2:0];
        default:
        begin
        end
      endcase
    end
    // Stop mode without async clock kills conversion
    if (stop_mode && !r_q.cfg[`ACRC_CFG_ACLK])
    begin
      abort = 1'b1;
    end
    // Converter sequencing
    unique case (r_q.st)
      acrc_pkg::ACRC_IDLE:
      begin
        if (start && !stop_mode)
        begin
          r_d.st = acrc_pkg::ACRC_CONV;
          r_d.cnt = 8'd0;
        end
      end
      acrc_pkg::ACRC_CONV:
      begin
        if (abort)
        begin
          // Results left as they were
          r_d.st = (start && !stop_mode) ? acrc_pkg::ACRC_CONV : acrc_pkg::ACRC_IDLE;
          r_d.cnt = 8'd0;
          ev[`ACRC_IST_ABORT] = 1'b1;
        end
        else if (conv_tick)
        begin
          if (r_q.cnt == conv_len - 8'd1)
          begin
            r_d.st = acrc_pkg::ACRC_DONE;
            r_d.sample = conv_data; // Latched while the analog side still drives it
          end
          r_d.cnt = r_q.cnt + 8'd1;
        end
      end
      acrc_pkg::ACRC_DONE:
      begin
        r_d.cnt = 8'd0;
        if (abort)
        begin
          r_d.st = (start && !stop_mode) ? acrc_pkg::ACRC_CONV : acrc_pkg::ACRC_IDLE;
          ev[`ACRC_IST_ABORT] = 1'b1;
        end
        else if (r_q.sc2[`ACRC_SC2_CMPEN] && !cmp_true)
        begin
          // Compare false: no transfer, single stops, continuous goes on
          r_d.st = r_q.sc1[`ACRC_SC1_CONT] ? acrc_pkg::ACRC_CONV : acrc_pkg::ACRC_IDLE;
        end
        else if (r_q.blocked)
        begin
          // Result lost, another conversion launched
          r_d.st = acrc_pkg::ACRC_CONV;
          ev[`ACRC_IST_DROP] = 1'b1;
        end
        else
        begin
          r_d.resh = {6'b000000, r_q.sample[9:8]};
          r_d.resl = r_q.sample[7:0];
          if (!mode10)
          begin
            r_d.resh = `ACRC_RESET_RES;
            r_d.resl = r_q.sample[9:2];
          end
          r_d.sc1[`ACRC_SC1_CONVERSION_COMPLETE_FLAG] = 1'b1;
          xfer = 1'b1;
          ev[`ACRC_IST_DONE] = 1'b1;
          r_d.st = r_q.sc1[`ACRC_SC1_CONT] ? acrc_pkg::ACRC_CONV : acrc_pkg::ACRC_IDLE;
        end
      end
      default: r_d.st = acrc_pkg::ACRC_IDLE;
    endcase
    // Drop the completion event unless the interrupt enable bit is set
    if (ev[`ACRC_IST_DONE] && !r_q.sc1[`ACRC_SC1_CONVERSION_INTERRUPT_ENABLE])
    begin
      ev[`ACRC_IST_DONE] = 1'b0;
    end
    // Reading the low result byte clears the complete flag; a result landing now wins
    if (rd && (r_q.ph_addr == `ACRC_OFS_RESL) && !xfer)
    begin
      r_d.sc1[`ACRC_SC1_CONVERSION_COMPLETE_FLAG] = 1'b0;
    end
    // Write-one-to-clear; a new event wins over the clear
    if (wr && r_q.ph_addr == `ACRC_OFS_IST)
    begin
      r_d.ist = r_q.ist & ~hwdata[2:0];
    end
    r_d.ist = r_d.ist | ev;
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r_q <= '0;
      r_q.st <= acrc_pkg::ACRC_IDLE;
      r_q.sc1 <= {3'b000, `ACRC_CH_OFF};
      r_q.resh <= `ACRC_RESET_RES;
      r_q.resl <= `ACRC_RESET_RES;
    end
    else if (clk_en)
    begin
      r_q <= r_d;
    end
  end

  // Completion sets the flag together with the result
  sequence done_seq;
    r_q.st == acrc_pkg::ACRC_DONE && clk_en;
  endsequence
  conversion_complete_flag_with_result_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(r_q.sc1[`ACRC_SC1_CONVERSION_COMPLETE_FLAG]) |-> $changed(r_q.resl) || $past(r_q.st) == acrc_pkg::ACRC_DONE)
    else $error("complete flag rose without transfer");
  irq_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($rose(r_q.sc1[`ACRC_SC1_CONVERSION_COMPLETE_FLAG]) && r_q.sc1[`ACRC_SC1_CONVERSION_INTERRUPT_ENABLE] && r_q.imsk[`ACRC_IST_DONE]) |-> irq)
    else $error("irq missing");
  block_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (r_q.blocked && clk_en && !abort_any()) |=> $stable(r_q.resh) && $stable(r_q.resl))
    else $error("blocked result overwritten");
  block_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (done_seq and (r_q.blocked && !r_q.sc2[`ACRC_SC2_CMPEN] && !abort_any()))
      |=> r_q.st == acrc_pkg::ACRC_CONV)
    else $error("blocked transfer did not restart");
  sc1_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && r_q.ph_valid && r_q.ph_write && r_q.ph_addr == `ACRC_OFS_SC1 && hwdata[4:0] == `ACRC_CH_OFF
      && !(r_q.st == acrc_pkg::ACRC_IDLE)) |=> r_q.st == acrc_pkg::ACRC_IDLE)
    else $error("all-ones channel did not stop");
  mode_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && r_q.ph_valid && r_q.ph_write && r_q.ph_addr == `ACRC_OFS_CFG) |=> $stable(r_q.resl))
    else $error("mode write altered result");
  stop_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && stop_mode && !r_q.cfg[`ACRC_CFG_ACLK] && conv_active) |=> !conv_active)
    else $error("stop did not abort conversion");
  pin_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    port_io_disable[23] == r_q.pc[15] && port_io_disable[9:8] == r_q.pc[1:0])
    else $error("pin map wrong");
  reset_res_a: assert property (@(posedge ref_clk)
    $past(sys_rst) |-> r_q.resh == `ACRC_RESET_RES && r_q.resl == `ACRC_RESET_RES && !conv_active)
    else $error("reset did not clear results");
  compare_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (done_seq and (r_q.sc2[`ACRC_SC2_CMPEN] && !cmp_true && !r_q.sc1[`ACRC_SC1_CONT] && !abort_any()))
      |=> r_q.st == acrc_pkg::ACRC_IDLE)
    else $error("compare-false single conversion kept running");
  blocked_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (done_seq and r_q.blocked) |=> !$rose(r_q.sc1[`ACRC_SC1_CONVERSION_COMPLETE_FLAG]))
    else $error("complete flag set on blocked result");
  sc1_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && r_q.ph_valid && r_q.ph_write && r_q.ph_addr == `ACRC_OFS_SC1 && hwdata[4:0] != `ACRC_CH_OFF
      && !stop_mode) |=> conv_active)
    else $error("control-one write did not start a conversion");
  conv_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    conv_active |-> r_q.cnt < conv_len)
    else $error("conversion ran past its cycle count");

  function automatic logic abort_any();
    abort_any = r_q.ph_valid && r_q.ph_write &&
      (r_q.ph_addr == `ACRC_OFS_SC1 || r_q.ph_addr == `ACRC_OFS_SC2 || r_q.ph_addr == `ACRC_OFS_CFG ||
       r_q.ph_addr == `ACRC_OFS_CVH || r_q.ph_addr == `ACRC_OFS_CVL) ||
      (stop_mode && !r_q.cfg[`ACRC_CFG_ACLK]);
  endfunction
endmodule
`default_nettype wire

// ===== logic/acrc_params.svh
`ifndef ACRC_PARAMS_SVH
`define ACRC_PARAMS_SVH
// Register byte addresses (one aligned word each)
`define ACRC_OFS_SC1 12'h000
`define ACRC_OFS_SC2 12'h004
`define ACRC_OFS_RESH 12'h008
`define ACRC_OFS_RESL 12'h00c
`define ACRC_OFS_CVH 12'h010
`define ACRC_OFS_CVL 12'h014
`define ACRC_OFS_CFG 12'h018
`define ACRC_OFS_PC2 12'h01c
`define ACRC_OFS_PC3 12'h020
`define ACRC_OFS_IST 12'h024
`define ACRC_OFS_IMSK 12'h028
`define ACRC_OFS_CTRL 12'h02c
// Status/control one fields
`define ACRC_SC1_CONVERSION_COMPLETE_FLAG 7
`define ACRC_SC1_CONVERSION_INTERRUPT_ENABLE 6
`define ACRC_SC1_CONT 5
// Status/control two fields
`define ACRC_SC2_BUSY 7
`define ACRC_SC2_CMPEN 5
`define ACRC_SC2_CMPGT 4
// Configuration fields
`define ACRC_CFG_MODE10 3
`define ACRC_CFG_LSMP 4
`define ACRC_CFG_ACLK 0
// Channel select all ones disables the converter
`define ACRC_CH_OFF 5'h1f
// Interrupt status bits
`define ACRC_IST_DONE 0
`define ACRC_IST_DROP 1
`define ACRC_IST_ABORT 2
// Conversion clock cycles per conversion, subsequent 10-bit short sample
`define ACRC_CONV_CYC 8'd20
`define ACRC_CONV_CYC_LONG 8'd40
`define ACRC_RESET_RES 8'h00
`endif

// ===== logic/acrc_pkg.sv
package acrc_pkg;
  typedef enum logic [2:0]
  {
    ACRC_IDLE = 3'b001,
    ACRC_CONV = 3'b010,
    ACRC_DONE = 3'b100
  } acrc_state_type;
endpackage

// ===== tb/acrc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acrc_analog_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Converter side
  input wire logic conv_active,
  input wire logic [9:0] sample_val,
  output logic conv_tick,
  output logic [9:0] conv_data
);
  logic [1:0] div_q;
  // Conversion clock at half bus rate; it stands still while idle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !conv_active)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end
  assign conv_tick = div_q[0];
  // Outside a conversion the level is junk, so show the inverse
  assign conv_data = conv_active ? sample_val : ~sample_val;
endmodule
`default_nettype wire

// ===== tb/adc_conversion_result_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "acrc_params.svh"
module adc_conversion_result_control_bench;
  logic ref_clk, sys_rst, hsel, hwrite, stop_mode, hrdy, hresp, tick, act, aclk, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [9:0] cdata, sval;
  logic [4:0] chan;
  logic [23:0] pins;
  int n_mismatch = 0;
  int cmp_count = 0;

  acrc_core #(.NUM_CH(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
    .conv_tick(tick), .conv_data(cdata), .stop_mode(stop_mode), .conv_channel(chan),
    .conv_active(act), .async_clk_enable(aclk), .port_io_disable(pins), .irq(irq));
  acrc_analog_model model (.ref_clk(ref_clk), .sys_rst(sys_rst), .conv_active(act),
    .sample_val(sval), .conv_tick(tick), .conv_data(cdata));

  // Free-running bus clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for the slave to be ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (hrdy !== 1'b1 && n < 64);
    if (hrdy !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d});
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] e);
    bus(a, 1'b0, 32'h0);
    check(what, rd, {24'h0, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Poll only the status register, so no result read disturbs the conversion
  task automatic wait_conversion_complete_flag();
    int n;
    n = 0;
    do
    begin
      bus(`ACRC_OFS_SC1, 1'b0, 32'h0);
      n++;
    end while (rd[`ACRC_SC1_CONVERSION_COMPLETE_FLAG] !== 1'b1 && n < 200);
    if (rd[`ACRC_SC1_CONVERSION_COMPLETE_FLAG] !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  initial
  begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    stop_mode = 1'b0;
    sval = 10'h2b7;
    idle(5);
    sys_rst <= 1'b0;
    idle(1);
    // Reset state and an unmapped place
    rchk("resh", `ACRC_OFS_RESH, 8'h00);
    rchk("resl", `ACRC_OFS_RESL, 8'h00);
    rchk("sc1", `ACRC_OFS_SC1, 8'h1f);
    rchk("unmapped", 12'h3fc, 8'h00);
    check("irq", {31'h0, irq}, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    // Pin handover, odd pattern to catch bit order slips
    wr(`ACRC_OFS_PC2, 8'ha5);
    wr(`ACRC_OFS_PC3, 8'h81);
    rchk("pc2", `ACRC_OFS_PC2, 8'ha5);
    rchk("pc3", `ACRC_OFS_PC3, 8'h81);
    check("pins", {8'h00, pins}, 32'h0081a500);
    // Single 10-bit conversion with interrupt
    wr(`ACRC_OFS_IMSK, 8'h01);
    wr(`ACRC_OFS_CFG, 8'h08);
    wr(`ACRC_OFS_SC1, 8'h42);
    wait_conversion_complete_flag();
    check("irq", {31'h0, irq}, 32'h1);
    rchk("resh", `ACRC_OFS_RESH, 8'h02);
    rchk("resl", `ACRC_OFS_RESL, 8'hb7);
    rchk("sc1", `ACRC_OFS_SC1, 8'h42);
    wr(`ACRC_OFS_IST, 8'h07);
    idle(2);
    check("irq", {31'h0, irq}, 32'h0);
    // Continuous mode, blocked mid-pair by a high read
    wr(`ACRC_OFS_SC1, 8'h22);
    wait_conversion_complete_flag();
    rchk("resh", `ACRC_OFS_RESH, 8'h02);
    sval <= 10'h155;
    idle(150);
    rchk("block", `ACRC_OFS_CTRL, 8'h01);
    rchk("resh", `ACRC_OFS_RESH, 8'h02);
    rchk("resl", `ACRC_OFS_RESL, 8'hb7);
    rchk("ist", `ACRC_OFS_IST, 8'h02);
    rchk("block", `ACRC_OFS_CTRL, 8'h00);
    wait_conversion_complete_flag();
    rchk("resh", `ACRC_OFS_RESH, 8'h01);
    rchk("resl", `ACRC_OFS_RESL, 8'h55);
    // Control-one writes restart or stop the converter
    sval <= 10'h3c3;
    wr(`ACRC_OFS_SC1, 8'h1b);
    idle(2);
    check("chan", {27'h0, chan}, 32'h1b);
    check("active", {31'h0, act}, 32'h1);
    wr(`ACRC_OFS_SC1, 8'h1f);
    idle(2);
    check("active", {31'h0, act}, 32'h0);
    // Compare-value-low write abort, async clock running meanwhile
    wr(`ACRC_OFS_CFG, 8'h09);
    wr(`ACRC_OFS_SC1, 8'h01);
    idle(2);
    check("aclk", {31'h0, aclk}, 32'h1);
    wr(`ACRC_OFS_CVL, 8'h00);
    idle(2);
    check("active", {31'h0, act}, 32'h0);
    // Stop without async clock
    wr(`ACRC_OFS_CFG, 8'h08);
    wr(`ACRC_OFS_SC1, 8'h01);
    idle(4);
    stop_mode <= 1'b1;
    idle(4);
    check("active", {31'h0, act}, 32'h0);
    stop_mode <= 1'b0;
    idle(60);
    rchk("resh", `ACRC_OFS_RESH, 8'h01);
    rchk("resl", `ACRC_OFS_RESL, 8'h55);
    // Single compare-false conversion while blocked just stops
    wr(`ACRC_OFS_SC2, 8'h20);
    rchk("resh", `ACRC_OFS_RESH, 8'h01);
    wr(`ACRC_OFS_SC1, 8'h01);
    idle(60);
    check("active", {31'h0, act}, 32'h0);
    rchk("resl", `ACRC_OFS_RESL, 8'h55);
    // Reset while idle clears results
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    idle(1);
    rchk("resh", `ACRC_OFS_RESH, 8'h00);
    rchk("resl", `ACRC_OFS_RESL, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
